// >>> gte_pkg.sv
// Shared constants, field layouts and types of the pin task and event unit.
// Assumes a single clock domain and a 32-bit AXI4-Lite register bus.
package gte_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [11:0] GTE_TASK_TRIGGER_OFF    = 12'h500;
  localparam logic [11:0] GTE_CHANNEL_STATUS_OFF  = 12'h504;
  localparam logic [11:0] GTE_CHANNEL_SETUP_2_OFF = 12'h518;
  localparam logic [11:0] GTE_CHANNEL_SETUP_3_OFF = 12'h51C;
  localparam logic [31:0] GTE_SETUP_RESET         = 32'h0000_0000;
  localparam logic [31:0] GTE_SETUP_MASK          = 32'h0013_3F03;

  // ----------------------------------------------------------------------
  // Field positions inside the trigger and status words
  // ----------------------------------------------------------------------
  localparam int GTE_TRIG_SET_POS = 0;
  localparam int GTE_TRIG_CLR_POS = 8;
  localparam int GTE_TRIG_OUT_POS = 16;
  localparam int GTE_STAT_LVL_POS = 0;
  localparam int GTE_STAT_PIN_POS = 8;

  // ----------------------------------------------------------------------
  // Pin space and bus answers
  // ----------------------------------------------------------------------
  localparam int          GTE_PIN_COUNT = 64;
  localparam logic [1:0]  GTE_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  GTE_RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    GTE_MODE_DIS  = 2'b00,
    GTE_MODE_EVT  = 2'b01,
    GTE_MODE_RSV  = 2'b10,
    GTE_MODE_TASK = 2'b11
  } gte_mode_t;

  typedef enum logic [1:0] {
    GTE_POL_NONE = 2'b00,
    GTE_POL_RISE = 2'b01,
    GTE_POL_FALL = 2'b10,
    GTE_POL_TOGG = 2'b11
  } gte_pol_t;

  // Channel setup word: mode 1:0, pin 12:8, port 13, polarity 17:16,
  // initial output 20.
  typedef struct packed {
    logic [10:0] rsv_31;
    logic        output_initial_level;
    logic [1:0]  rsv_19;
    gte_pol_t    pol;
    logic [1:0]  rsv_15;
    logic        port;
    logic [4:0]  pin;
    logic [5:0]  rsv_7;
    gte_mode_t   mode;
  } gte_setup_t;

endpackage

// >>> gte_channels.sv
// Pin task and event channels with an AXI4-Lite register slave.
// Assumes pins and task strobes are synchronous to aclk.
`timescale 1ns/1ps

module gte_channels #(
  parameter int NUM_CH = 2
) (
  input  wire logic                              aclk,
  input  wire logic                              aresetn,
  input  wire logic [11:0]                       s_axi_awaddr,
  input  wire logic                              s_axi_awvalid,
  output      logic                              s_axi_awready,
  input  wire logic [31:0]                       s_axi_wdata,
  input  wire logic [3:0]                        s_axi_wstrb,
  input  wire logic                              s_axi_wvalid,
  output      logic                              s_axi_wready,
  output      logic [1:0]                        s_axi_bresp,
  output      logic                              s_axi_bvalid,
  input  wire logic                              s_axi_bready,
  input  wire logic [11:0]                       s_axi_araddr,
  input  wire logic                              s_axi_arvalid,
  output      logic                              s_axi_arready,
  output      logic [31:0]                       s_axi_rdata,
  output      logic [1:0]                        s_axi_rresp,
  output      logic                              s_axi_rvalid,
  input  wire logic                              s_axi_rready,
  input  wire logic [NUM_CH-1:0]                 task_set,
  input  wire logic [NUM_CH-1:0]                 channel_clear_task,
  input  wire logic [NUM_CH-1:0]                 task_out,
  output      logic [NUM_CH-1:0]                 in_event,
  input  wire logic [gte_pkg::GTE_PIN_COUNT-1:0] gpio_out,
  input  wire logic [gte_pkg::GTE_PIN_COUNT-1:0] gpio_oe,
  input  wire logic [gte_pkg::GTE_PIN_COUNT-1:0] pin_i,
  output      logic [gte_pkg::GTE_PIN_COUNT-1:0] pin_o,
  output      logic [gte_pkg::GTE_PIN_COUNT-1:0] pin_oe
);

  // ----------------------------------------------------------------------
  // Storage and internal signals
  // ----------------------------------------------------------------------
  gte_pkg::gte_setup_t              setup_q [NUM_CH];
  logic [NUM_CH-1:0]                out_q;
  logic [NUM_CH-1:0]                prev_q;
  logic [NUM_CH-1:0]                arm_q;
  logic [NUM_CH-1:0]                event_q;
  logic [NUM_CH-1:0]                wr_setup;
  logic [NUM_CH-1:0]                do_set;
  logic [NUM_CH-1:0]                do_clr;
  logic [NUM_CH-1:0]                do_out;
  logic [NUM_CH-1:0]                cur_lvl;
  logic [5:0]                       sel [NUM_CH];
  logic [gte_pkg::GTE_PIN_COUNT-1:0] pin_o_d;
  logic [gte_pkg::GTE_PIN_COUNT-1:0] pin_oe_d;
  logic [gte_pkg::GTE_PIN_COUNT-1:0] pin_o_q;
  logic [gte_pkg::GTE_PIN_COUNT-1:0] pin_oe_q;
  logic [11:0]                      awaddr_q;
  logic                             aw_full_q;
  logic [31:0]                      wdata_q;
  logic [3:0]                       wstrb_q;
  logic                             w_full_q;
  logic                             bvalid_q;
  logic [1:0]                       bresp_q;
  logic                             rvalid_q;
  logic [31:0]                      rdata_q;
  logic [1:0]                       rresp_q;
  logic                             wr_fire;
  logic                             wr_trig;
  logic [31:0]                      wr_bytes;
  logic [31:0]                      stat_word;
  gte_pkg::gte_setup_t              wr_word;

  // ----------------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------------
  // Address and data are each held until both are present.
  assign s_axi_awready = !aw_full_q;
  assign s_axi_wready  = !w_full_q;
  assign wr_fire       = aw_full_q && w_full_q && !bvalid_q;
  assign wr_trig       = wr_fire && (awaddr_q == gte_pkg::GTE_TASK_TRIGGER_OFF);
  assign wr_word       = wr_bytes;

  // Byte lanes without a strobe are zeroed; setup writes merge the stored value back in.
  always_comb begin
    wr_bytes = 32'h0000_0000;
    for (int b = 0; b < 4; b++) begin
      wr_bytes[b*8 +: 8] = wstrb_q[b] ? wdata_q[b*8 +: 8] : 8'h00;
    end
  end

  // Capture of the address channel.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      awaddr_q  <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_q <= 1'b1;
      awaddr_q  <= {s_axi_awaddr[11:2], 2'b00};
    end else if (wr_fire) begin
      aw_full_q <= 1'b0;
    end
  end

  // Capture of the data channel.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_q <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_full_q <= 1'b0;
    end
  end

  // Write response; unmapped addresses answer with a slave error.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= gte_pkg::GTE_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      if ((|wr_setup) || wr_trig) begin
        bresp_q <= gte_pkg::GTE_RESP_OKAY;
      end else begin
        bresp_q <= gte_pkg::GTE_RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // ----------------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------------
  // Level driven by each channel and the level sampled on its pin.
  always_comb begin
    stat_word = 32'h0000_0000;
    for (int c = 0; c < NUM_CH; c++) begin
      stat_word[gte_pkg::GTE_STAT_LVL_POS + c] = out_q[c];
      stat_word[gte_pkg::GTE_STAT_PIN_POS + c] = cur_lvl[c];
    end
  end
  assign s_axi_arready = !rvalid_q;

  // One read is answered in the cycle after it is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= gte_pkg::GTE_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= gte_pkg::GTE_RESP_SLVERR;
      if (s_axi_araddr[11:2] == gte_pkg::GTE_CHANNEL_STATUS_OFF[11:2]) begin
        rdata_q <= stat_word;
        rresp_q <= gte_pkg::GTE_RESP_OKAY;
      end else if (s_axi_araddr[11:2] ==
                   gte_pkg::GTE_TASK_TRIGGER_OFF[11:2]) begin
        rresp_q <= gte_pkg::GTE_RESP_OKAY; // Trigger reads as zero.
      end else begin
        for (int c = 0; c < NUM_CH; c++) begin
          if (s_axi_araddr[11:2] ==
              10'(gte_pkg::GTE_CHANNEL_SETUP_2_OFF[11:2] + c)) begin
            rdata_q <= setup_q[c];
            rresp_q <= gte_pkg::GTE_RESP_OKAY;
          end
        end
      end
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

  // ----------------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------------
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    // Setup writes, task strobes from the port and the trigger register.
    assign wr_setup[c] = wr_fire && (awaddr_q ==
                         12'(gte_pkg::GTE_CHANNEL_SETUP_2_OFF + 4 * c));
    assign do_set[c] = task_set[c] ||
                       (wr_trig && wr_bytes[gte_pkg::GTE_TRIG_SET_POS + c]);
    assign do_clr[c] = channel_clear_task[c] ||
                       (wr_trig && wr_bytes[gte_pkg::GTE_TRIG_CLR_POS + c]);
    assign do_out[c] = task_out[c] ||
                       (wr_trig && wr_bytes[gte_pkg::GTE_TRIG_OUT_POS + c]);
    assign sel[c]     = {setup_q[c].port, setup_q[c].pin};
    assign cur_lvl[c] = pin_i[sel[c]];

    // Setup register; reserved bits are never stored.
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        setup_q[c] <= gte_pkg::GTE_SETUP_RESET;
      end else if (wr_setup[c]) begin
        setup_q[c] <= (wr_bytes | (setup_q[c] & ~{{8{wstrb_q[3]}},
                       {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}}))
                      & gte_pkg::GTE_SETUP_MASK;
      end
    end

    // Output level: set beats clear, clear beats the output task.
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        out_q[c] <= 1'b0;
      end else if (wr_setup[c] &&
                   wr_word.mode == gte_pkg::GTE_MODE_TASK) begin
        out_q[c] <= wr_word.output_initial_level;
      end else if (setup_q[c].mode == gte_pkg::GTE_MODE_TASK) begin
        if (do_set[c]) begin
          out_q[c] <= 1'b1;
        end else if (do_clr[c]) begin
          out_q[c] <= 1'b0;
        end else if (do_out[c]) begin
          case (setup_q[c].pol)
            gte_pkg::GTE_POL_RISE: out_q[c] <= 1'b1;
            gte_pkg::GTE_POL_FALL: out_q[c] <= 1'b0;
            gte_pkg::GTE_POL_TOGG: out_q[c] <= !out_q[c];
            default:               out_q[c] <= out_q[c];
          endcase
        end
      end
    end

    // Edge detector; disarmed for a cycle after a setup write of this channel so that a
    // change of the selected pin is not taken for an edge.
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        prev_q[c] <= 1'b0;
        arm_q[c]  <= 1'b0;
      end else begin
        prev_q[c] <= cur_lvl[c];
        arm_q[c]  <= !wr_setup[c];
      end
    end

    // Input event pulse chosen by polarity.
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        event_q[c] <= 1'b0;
      end else if (arm_q[c] && !wr_setup[c] &&
                   setup_q[c].mode == gte_pkg::GTE_MODE_EVT) begin
        case (setup_q[c].pol)
          gte_pkg::GTE_POL_RISE: event_q[c] <= cur_lvl[c] && !prev_q[c];
          gte_pkg::GTE_POL_FALL: event_q[c] <= !cur_lvl[c] && prev_q[c];
          gte_pkg::GTE_POL_TOGG: event_q[c] <= cur_lvl[c] ^ prev_q[c];
          default:               event_q[c] <= 1'b0;
        endcase
      end else begin
        event_q[c] <= 1'b0;
      end
    end
  end
  assign in_event = event_q;

  // ----------------------------------------------------------------------
  // Pin ownership
  // ----------------------------------------------------------------------
  // GPIO drives by default; event pins become inputs; task pins are driven
  // by the channel, the highest channel winning on a shared pin.
  always_comb begin
    pin_o_d  = gpio_out;
    pin_oe_d = gpio_oe;
    for (int c = 0; c < NUM_CH; c++) begin
      if (setup_q[c].mode == gte_pkg::GTE_MODE_EVT) begin
        pin_oe_d[sel[c]] = 1'b0;
      end
    end
    for (int c = 0; c < NUM_CH; c++) begin
      if (setup_q[c].mode == gte_pkg::GTE_MODE_TASK) begin
        pin_oe_d[sel[c]] = 1'b1;
        pin_o_d[sel[c]]  = out_q[c];
      end
    end
  end

  // Registered pin drive.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_o_q  <= '0;
      pin_oe_q <= '0;
    end else begin
      pin_o_q  <= pin_o_d;
      pin_oe_q <= pin_oe_d;
    end
  end
  assign pin_o  = pin_o_q;
  assign pin_oe = pin_oe_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  localparam int TOP = NUM_CH - 1;
  sequence top_task_s;
    setup_q[TOP].mode == gte_pkg::GTE_MODE_TASK && !wr_setup[TOP];
  endsequence
  no_event_off_a: assert property (
    setup_q[0].mode != gte_pkg::GTE_MODE_EVT |=> !in_event[0])
    else $error("event raised outside event mode");
  evt_input_a: assert property (
    setup_q[0].mode == gte_pkg::GTE_MODE_EVT && !(|wr_setup) &&
    !(setup_q[TOP].mode == gte_pkg::GTE_MODE_TASK && sel[TOP] == sel[0])
    |=> !pin_oe[$past(sel[0])])
    else $error("event pin still driven");
  task_drive_a: assert property (
    top_task_s ##1 top_task_s |-> pin_oe[sel[TOP]] &&
    pin_o[sel[TOP]] == $past(out_q[TOP]))
    else $error("task pin not driven by channel");
  gpio_blocked_a: assert property (
    top_task_s ##0 $changed(gpio_out[sel[TOP]]) |=>
    pin_o[$past(sel[TOP])] == $past(out_q[TOP]))
    else $error("gpio write reached owned pin");
  change_event_a: assert property (
    arm_q[0] && !wr_setup[0] && setup_q[0].mode == gte_pkg::GTE_MODE_EVT &&
    setup_q[0].pol == gte_pkg::GTE_POL_TOGG && cur_lvl[0] != prev_q[0]
    |=> in_event[0])
    else $error("change on selected pin missed");
  none_hold_a: assert property (
    setup_q[0].mode == gte_pkg::GTE_MODE_TASK && !wr_setup[0] &&
    setup_q[0].pol == gte_pkg::GTE_POL_NONE && !do_set[0] && !do_clr[0]
    |=> $stable(out_q[0]))
    else $error("output task changed pin with no polarity");
  rise_event_a: assert property (
    arm_q[0] && !wr_setup[0] && setup_q[0].mode == gte_pkg::GTE_MODE_EVT &&
    setup_q[0].pol == gte_pkg::GTE_POL_RISE
    |=> in_event[0] == ($past(cur_lvl[0]) && !$past(prev_q[0])))
    else $error("rising edge event wrong");
  fall_event_a: assert property (
    arm_q[0] && !wr_setup[0] && setup_q[0].mode == gte_pkg::GTE_MODE_EVT &&
    setup_q[0].pol == gte_pkg::GTE_POL_FALL
    |=> in_event[0] == (!$past(cur_lvl[0]) && $past(prev_q[0])))
    else $error("falling edge event wrong");
  toggle_out_a: assert property (
    setup_q[0].mode == gte_pkg::GTE_MODE_TASK && !wr_setup[0] &&
    setup_q[0].pol == gte_pkg::GTE_POL_TOGG && do_out[0] &&
    !do_set[0] && !do_clr[0] |=> out_q[0] != $past(out_q[0]))
    else $error("toggle task did not invert");
  init_level_a: assert property (
    wr_setup[0] && wr_word.mode == gte_pkg::GTE_MODE_TASK
    |=> out_q[0] == $past(wr_word.output_initial_level))
    else $error("initial level not applied");
  reserved_zero_a: assert property (
    1'b1 |-> (setup_q[0] & ~gte_pkg::GTE_SETUP_MASK) == 32'h0000_0000)
    else $error("reserved setup bits stored");
endmodule

// >>> gte_pin_model.sv
// Board circuitry seen by the 64 pins of the task and event unit.
// Assumes the bench chooses which pins it drives and at what level.
`timescale 1ns/1ps

module gte_pin_model (
  input  wire logic                              aclk,
  input  wire logic [gte_pkg::GTE_PIN_COUNT-1:0] pin_o,
  input  wire logic [gte_pkg::GTE_PIN_COUNT-1:0] pin_oe,
  input  wire logic [gte_pkg::GTE_PIN_COUNT-1:0] ext_en,
  input  wire logic [gte_pkg::GTE_PIN_COUNT-1:0] ext_lvl,
  output      logic [gte_pkg::GTE_PIN_COUNT-1:0] pin_i
);
  logic [gte_pkg::GTE_PIN_COUNT-1:0] float_q = 64'h5555_5555_5555_5555;

  // Pins with no driver and no pull wander, so stale levels never pass.
  always_ff @(posedge aclk) begin
    float_q <= ~float_q;
  end

  // The unit's own driver wins, then the board's, then the floating level.
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_lvl) |
                 (~pin_oe & ~ext_en & float_q);
endmodule

// >>> gte_channels_tb.sv
// Self-checking bench for the pin task and event channels.
// Assumes a 100 ns clock and the register map of the shared package.
`timescale 1ns/1ps

module gte_channels_tb;
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] pol;
    logic       init;
    logic       lv0;
    logic       lv1;
    logic [1:0] n_rise;
    logic [1:0] n_fall;
  } gte_row_t;

  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000, rdata, rd;
  logic [3:0]  wstrb = 4'hF;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rsp;
  logic [1:0]  t_set = 2'h0, t_clr = 2'h0, t_out = 2'h0;
  logic [1:0]  in_event;
  logic [63:0] gpio_out = '1, gpio_oe = '1, ext_lvl = '0;
  logic [63:0] ext_en = 64'h0000_0000_0000_0008;
  logic [63:0] pin_i, pin_o, pin_oe;
  int          bad_count = 0, checks = 0, nr, nf;
  gte_row_t    rows [9];

  gte_channels #(.NUM_CH(2)) gte_channels_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .task_set(t_set),
    .channel_clear_task(t_clr), .task_out(t_out), .in_event(in_event),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe(pin_oe));

  gte_pin_model gte_pin_model_inst (
    .aclk(aclk), .pin_o(pin_o), .pin_oe(pin_oe), .ext_en(ext_en),
    .ext_lvl(ext_lvl), .pin_i(pin_i));

  // Free-running 10 MHz clock.
  initial begin
    forever #50 aclk = ~aclk;
  end

  // Builds a setup word: mode 1:0, pin 12:8, port 13, polarity 17:16, 20.
  function automatic logic [31:0] setup(logic [1:0] m, logic [1:0] p,
                                        logic i, logic pt, logic [4:0] pn);
    return {11'h000, i, 2'h0, p, 2'h0, pt, pn, 6'h00, m};
  endfunction

  // Compares a word and counts the outcome.
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Compares a single pin or flag level.
  task automatic chk_bit(string what, logic exp, logic got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask

  // One AXI4-Lite write; address and data are released as each is taken.
  task automatic axi_write(logic [11:0] a, logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask

  // One AXI4-Lite read; data and response are taken at the rvalid edge.
  task automatic axi_read(logic [11:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask

  // Pulses one task strobe of channel 0 for a cycle: 0 set, 1 clear, 2 out.
  task automatic pulse(int kind);
    @(posedge aclk);
    t_set[0] <= (kind == 0);
    t_clr[0] <= (kind == 1);
    t_out[0] <= (kind == 2);
    @(posedge aclk);
    t_set <= 2'h0;
    t_clr <= 2'h0;
    t_out <= 2'h0;
    repeat (3) @(posedge aclk);
  endtask

  // Counts events of one channel over four edges after moving pin 3.
  task automatic move_pin(logic lvl, int ch, output int n);
    n = 0;
    ext_lvl[3] <= lvl;
    repeat (4) begin
      @(posedge aclk);
      if (in_event[ch] === 1'b1) n++;
    end
  endtask

  // Ends the run with the counts and the verdict.
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Cuts a hung run short.
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    complete_run;
  end

  // Main sequence: reset, table of modes and polarities, then odd cases.
  initial begin
    rows[0] = {2'd0, 2'd0, 1'b0, 1'b1, 1'b1, 2'd0, 2'd0};
    rows[1] = {2'd3, 2'd0, 1'b0, 1'b0, 1'b0, 2'd0, 2'd0};
    rows[2] = {2'd3, 2'd1, 1'b0, 1'b0, 1'b1, 2'd0, 2'd0};
    rows[3] = {2'd3, 2'd2, 1'b1, 1'b1, 1'b0, 2'd0, 2'd0};
    rows[4] = {2'd3, 2'd3, 1'b0, 1'b0, 1'b1, 2'd0, 2'd0};
    rows[5] = {2'd1, 2'd0, 1'b1, 1'b0, 1'b0, 2'd0, 2'd0};
    rows[6] = {2'd1, 2'd1, 1'b1, 1'b0, 1'b0, 2'd1, 2'd0};
    rows[7] = {2'd1, 2'd2, 1'b1, 1'b0, 1'b0, 2'd0, 2'd1};
    rows[8] = {2'd1, 2'd3, 1'b1, 1'b0, 1'b0, 2'd1, 2'd1};
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(12'h518);
    chk("setup_2 reset", 32'h0000_0000, rd);
    axi_read(12'h51C);
    chk("setup_3 reset", 32'h0000_0000, rd);
    axi_write(12'h51C, 32'hFFFF_FFFF);
    axi_read(12'h51C);
    chk("setup_3 fields", 32'h0013_3F03, rd);
    axi_write(12'h600, 32'h0000_0001);
    chk("unmapped write resp", 32'h2, 32'(rsp));
    axi_read(12'h600);
    chk("unmapped read resp", 32'h2, 32'(rsp));
    // Channel 1 takes port 0 pin 5 and must leave port 1 pin 5 alone.
    axi_write(12'h51C, setup(2'd3, 2'd0, 1'b1, 1'b0, 5'd5));
    gpio_out[5] <= 1'b0;
    gpio_out[37] <= 1'b0;
    repeat (3) @(posedge aclk);
    chk_bit("pin 5 level", 1'b1, pin_o[5]);
    chk_bit("pin 37 level", 1'b0, pin_o[37]);
    gpio_out[37] <= 1'b1;
    foreach (rows[k]) begin
      if (rows[k].mode == 2'd1) begin
        axi_write(12'h518, setup(2'd1, rows[k].pol, 1'b1, 1'b0, 5'd3));
        repeat (3) @(posedge aclk);
        chk_bit("event pin oe", 1'b0, pin_oe[3]);
        move_pin(1'b1, 0, nr);
        move_pin(1'b0, 0, nf);
        chk("rise events", 32'(rows[k].n_rise), 32'(nr));
        chk("fall events", 32'(rows[k].n_fall), 32'(nf));
      end else begin
        axi_write(12'h518, setup(rows[k].mode, rows[k].pol, rows[k].init,
                                 1'b1, 5'd5));
        repeat (3) @(posedge aclk);
        chk_bit("pin oe", 1'b1, pin_oe[37]);
        chk_bit("pin initial", rows[k].lv0, pin_o[37]);
        pulse(2);
        chk_bit("pin after out", rows[k].lv1, pin_o[37]);
      end
    end
    // Set and clear tasks on an owned pin, with the GPIO path pulling high.
    axi_write(12'h518, setup(2'd3, 2'd0, 1'b0, 1'b1, 5'd5));
    pulse(0);
    chk_bit("pin after set", 1'b1, pin_o[37]);
    gpio_out[37] <= 1'b1;
    pulse(1);
    chk_bit("pin after clear", 1'b0, pin_o[37]);
    chk_bit("pin 5 held", 1'b1, pin_o[5]);
    // Trigger register sets channel 0 and clears channel 1; status follows.
    axi_write(12'h500, 32'h0000_0201);
    chk("trigger resp", 32'h0, 32'(rsp));
    repeat (2) @(posedge aclk);
    chk_bit("pin 5 after clear", 1'b0, pin_o[5]);
    axi_read(12'h504);
    chk("status word", 32'h0000_0101, rd);
    // Mode 2 hands pin 37 back to the GPIO path.
    axi_write(12'h518, setup(2'd2, 2'd3, 1'b0, 1'b1, 5'd5));
    repeat (3) @(posedge aclk);
    chk_bit("reserved mode pin", 1'b1, pin_o[37]);
    // Channel 1 watches rising edges on pin 3.
    axi_write(12'h51C, setup(2'd1, 2'd1, 1'b0, 1'b0, 5'd3));
    repeat (3) @(posedge aclk);
    move_pin(1'b1, 1, nr);
    move_pin(1'b0, 1, nf);
    chk("ch1 rise events", 32'd1, 32'(nr));
    chk("ch1 fall events", 32'd0, 32'(nf));
    // Reset in mid-run clears the setups and releases every pin.
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    chk_bit("pins released", 1'b0, |pin_oe);
    chk("events in reset", 32'h0, 32'(in_event));
    aresetn <= 1'b1;
    axi_read(12'h51C);
    chk("setup_3 after reset", 32'h0000_0000, rd);
    complete_run;
  end
endmodule
